//--- rtl/sac_pkg.sv
package sac_pkg;

  // reading width; readings run to 59999 plus sign and headroom
  localparam int SAC_MEAS_W_DEF = 20;
  localparam int SAC_ADDR_W = 4;
  localparam int SAC_DELAY_W = 7;

  // register indices on the configuration port
  localparam logic [3:0] SAC_REG_CTL_CFG = 4'h0;
  localparam logic [3:0] SAC_REG_ALM_CFG = 4'h1;
  localparam logic [3:0] SAC_REG_ALM_FUNC = 4'h2;
  localparam logic [3:0] SAC_REG_ALM_DELAY = 4'h3;
  localparam logic [3:0] SAC_REG_CTL_HYST = 4'h4;
  localparam logic [3:0] SAC_REG_ALM_HYST = 4'h5;
  localparam logic [3:0] SAC_REG_LEVEL_BASE = 4'h6;
  localparam logic [3:0] SAC_REG_LOCK1 = 4'ha;
  localparam logic [3:0] SAC_REG_LOCK3 = 4'hb;
  localparam logic [3:0] SAC_REG_STATUS = 4'hc;
  localparam int SAC_NUM_LEVELS = 4;

  // per-channel field layout inside both config bytes, stride 3
  localparam int SAC_CH_STRIDE = 3;
  localparam int SAC_DIR_OFS = 0;
  localparam int SAC_POL_OFS = 1;
  localparam int SAC_SRC_OFS = 2;
  localparam int SAC_PAIR_DIS_BIT = 6;
  localparam int SAC_LED_DIS_BIT = 7;
  localparam int SAC_EXT_EN_BIT = 7;

  // alarm function byte: placement two bits then latch, per alarm
  localparam int SAC_PLACE_OFS = 0;
  localparam int SAC_LATCH_OFS = 2;
  localparam int SAC_FUNC_W = 6;

  // third lockout byte bits that guard the setpoint features
  localparam logic [7:0] SAC_FEATURE_LOCK_MASK = 8'h7e;

  // reset values of the configuration
  localparam logic [7:0] SAC_CFG_RST = 8'h00;
  localparam logic [7:0] SAC_LOCK_RST = 8'h00;

  // synchronised pins: {jumper, button_n, ext_n}, idle value
  localparam logic [2:0] SAC_PIN_IDLE = 3'h3;
  localparam int SAC_PIN_EXT = 0;
  localparam int SAC_PIN_BTN = 1;
  localparam int SAC_PIN_JMP = 2;

  typedef enum logic [1:0] {
    SAC_PLACE_INDEP = 2'h0,
    SAC_PLACE_ABOVE = 2'h1,
    SAC_PLACE_BELOW = 2'h2,
    SAC_PLACE_BAND = 2'h3
  } sac_place_t;

endpackage

//--- rtl/sac_zone_eval.sv
`timescale 1ns/10ps
module sac_zone_eval #(
  parameter int W = 21
) (
  input wire logic signed [W-1:0] meas,
  input wire logic signed [W-1:0] lo,
  input wire logic signed [W-1:0] hi,
  input wire logic signed [W-1:0] enter_ofs,
  input wire logic signed [W-1:0] stay_ofs,
  input wire logic band,
  input wire logic below,
  output logic enter,
  output logic stay
);
  localparam int XW = W + 2;

  logic signed [XW-1:0] m;
  logic signed [XW-1:0] hi_up_e;
  logic signed [XW-1:0] hi_dn_e;
  logic signed [XW-1:0] hi_up_x;
  logic signed [XW-1:0] hi_dn_x;
  logic signed [XW-1:0] lo_up_e;
  logic signed [XW-1:0] lo_dn_e;
  logic signed [XW-1:0] lo_up_x;
  logic signed [XW-1:0] lo_dn_x;

  // two guard bits so no edge of the band can wrap
  assign m = XW'(meas);
  assign hi_up_e = XW'(hi) + XW'(enter_ofs);
  assign hi_dn_e = XW'(hi) - XW'(enter_ofs);
  assign hi_up_x = XW'(hi) + XW'(stay_ofs);
  assign hi_dn_x = XW'(hi) - XW'(stay_ofs);
  assign lo_up_e = XW'(lo) + XW'(enter_ofs);
  assign lo_dn_e = XW'(lo) - XW'(enter_ofs);
  assign lo_up_x = XW'(lo) + XW'(stay_ofs);
  assign lo_dn_x = XW'(lo) - XW'(stay_ofs);

  // enter decides a fresh activation, stay keeps an active one
  always_comb begin
    if (band && !below) begin
      enter = (m > hi_up_e) || (m < lo_dn_e);
      stay = (m >= hi_dn_x) || (m <= lo_up_x);
    end else if (band) begin
      enter = (m > lo_up_e) && (m < hi_dn_e);
      stay = (m >= lo_dn_x) && (m <= hi_up_x);
    end else if (below) begin
      enter = m < lo_dn_e;
      stay = m <= lo_up_x;
    end else begin
      enter = m > hi_up_e;
      stay = m >= hi_dn_x;
    end
  end

endmodule

//--- rtl/sac_setpoint_alarm.sv
`timescale 1ns/10ps
// Contract
// - control hysteresis split half above, half below
// - alarm hysteresis wholly on inactive side
// - alarm sets at once, releases past hysteresis
// - control setpoints never latch
// - control direction bit: 0 above, 1 below
// - control polarity: 0 transistor on while active
// - control source: 0 raw, 1 filtered
// - shared bit disables both control setpoints
// - control lights need enable and light-enable
// - alarm direction bit: 0 above, 1 below
// - band alarm: outside or inside by direction
// - deviation threshold is control value plus or minus alarm value
// - alarm polarity: 0 output on while active
// - alarm source: 0 raw, 1 filtered
// - shared bit disables both alarms and lights
// - external reset pin honoured only when enabled
// - panel edits blocked by jumper or lockout
// - evaluation continues while levels are edited
// - placement code: independent, above, below, band
// - latched alarm holds until a reset source
// - alarm waits for consecutive qualifying readings
module sac_setpoint_alarm import sac_pkg::*; #(
  parameter int MEAS_W = SAC_MEAS_W_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic MEAS_VALID,
  input wire logic signed [MEAS_W-1:0] MEAS_RAW,
  input wire logic signed [MEAS_W-1:0] MEAS_FILT,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic RESET_BUTTON_N,
  input wire logic LOCK_JUMPER,
  input wire logic SER_LATCH_CLEAR,
  input wire logic CFG_WE,
  input wire logic CFG_FROM_SERIAL,
  input wire logic [SAC_ADDR_W-1:0] CFG_ADDR,
  input wire logic [MEAS_W-1:0] CFG_WDATA,
  output logic [MEAS_W-1:0] CFG_RDATA,
  output logic [3:0] SP_ACTIVE,
  output logic [3:0] OC_ON,
  output logic [3:0] LED_ON
);
  localparam int TW = MEAS_W + 1;

  // configuration state
  logic [7:0] control_setpoint_config_q;
  logic [7:0] alarm_setpoint_config_q;
  logic [SAC_FUNC_W-1:0] alm_func_q;
  logic [2*SAC_DELAY_W-1:0] alarm_delay_count_q;
  logic signed [MEAS_W-1:0] ctl_hyst_q;
  logic signed [MEAS_W-1:0] alm_hyst_q;
  logic signed [MEAS_W-1:0] level_q [SAC_NUM_LEVELS];
  logic [7:0] first_lockout_byte_q;
  logic [7:0] third_lockout_byte_q;

  // evaluation state; one register per pair so each has a single writer
  logic [1:0] ctl_act_q;
  logic [1:0] alm_act_q;
  logic [3:0] active_q;
  logic [SAC_DELAY_W-1:0] dcnt_q [2];
  logic [3:0] oc_q;
  logic [3:0] led_q;
  logic [MEAS_W-1:0] rdata_q;

  // pin synchronisers
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;

  logic ctl_pair_disable;
  logic ctl_indicator_disable;
  logic alm_pair_disable;
  logic external_latch_reset_enable;
  logic jumper_in;
  logic button_press;
  logic ext_press;
  logic latch_clear;
  logic wr_ok;

  logic [3:0] dir;
  logic [3:0] pol;
  logic [3:0] band;
  logic [1:0] latch_en;
  logic [1:0] set_now;
  logic [3:0] enter;
  logic [3:0] stay;
  logic signed [TW-1:0] meas_sel [4];
  logic signed [TW-1:0] thr_lo [4];
  logic signed [TW-1:0] thr_hi [4];
  logic signed [TW-1:0] ofs_enter [4];
  logic signed [TW-1:0] ofs_stay [4];

  function automatic logic signed [TW-1:0] widen(input logic signed [MEAS_W-1:0] v);
    widen = TW'(v);
  endfunction

  // does a panel write to this index hit a lockout
  function automatic logic panel_locked(input logic [SAC_ADDR_W-1:0] a,
                                        input logic [7:0] l1,
                                        input logic [7:0] l3);
    logic [SAC_ADDR_W-1:0] idx;
    idx = a - SAC_REG_LEVEL_BASE;
    if (a >= SAC_REG_LEVEL_BASE && a < SAC_REG_LOCK1) begin
      panel_locked = l1[idx[1:0]];
    end else if (a < SAC_REG_LEVEL_BASE) begin
      panel_locked = |(l3 & SAC_FEATURE_LOCK_MASK);
    end else begin
      panel_locked = 1'b0;
    end
  endfunction

  assign ctl_pair_disable = control_setpoint_config_q[SAC_PAIR_DIS_BIT];
  assign ctl_indicator_disable = control_setpoint_config_q[SAC_LED_DIS_BIT];
  assign alm_pair_disable = alarm_setpoint_config_q[SAC_PAIR_DIS_BIT];
  assign external_latch_reset_enable = alarm_setpoint_config_q[SAC_EXT_EN_BIT];

  // two flops before anything reads a pin; third stage only for edges
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_s1_q <= SAC_PIN_IDLE;
      pin_s2_q <= SAC_PIN_IDLE;
      pin_s3_q <= SAC_PIN_IDLE;
    end else begin
      pin_s1_q <= {LOCK_JUMPER, RESET_BUTTON_N, EXTERNAL_RESET_PIN_N};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign jumper_in = pin_s2_q[SAC_PIN_JMP];
  assign button_press = !pin_s2_q[SAC_PIN_BTN] && pin_s3_q[SAC_PIN_BTN];
  // grounding the pin clears latches only when enabled
  assign ext_press = !pin_s2_q[SAC_PIN_EXT] && pin_s3_q[SAC_PIN_EXT] && external_latch_reset_enable;
  assign latch_clear = button_press || ext_press || SER_LATCH_CLEAR;

  // serial boards always write; panel needs jumper and no lockout
  assign wr_ok = CFG_WE && (CFG_FROM_SERIAL ||
                 (jumper_in && !panel_locked(CFG_ADDR, first_lockout_byte_q, third_lockout_byte_q)));

  // configuration writes; levels may change mid-run without stalling evaluation
  always_ff @(posedge MCLK) begin
    if (RST) begin
      control_setpoint_config_q <= SAC_CFG_RST;
      alarm_setpoint_config_q <= SAC_CFG_RST;
      alm_func_q <= SAC_FUNC_W'(SAC_CFG_RST);
      alarm_delay_count_q <= '0;
      ctl_hyst_q <= '0;
      alm_hyst_q <= '0;
      first_lockout_byte_q <= SAC_LOCK_RST;
      third_lockout_byte_q <= SAC_LOCK_RST;
      for (int i = 0; i < SAC_NUM_LEVELS; i++) begin
        level_q[i] <= '0;
      end
    end else if (wr_ok) begin
      case (CFG_ADDR)
        SAC_REG_CTL_CFG: control_setpoint_config_q <= CFG_WDATA[7:0];
        SAC_REG_ALM_CFG: alarm_setpoint_config_q <= CFG_WDATA[7:0];
        SAC_REG_ALM_FUNC: alm_func_q <= CFG_WDATA[SAC_FUNC_W-1:0];
        SAC_REG_ALM_DELAY: alarm_delay_count_q <= CFG_WDATA[2*SAC_DELAY_W-1:0];
        SAC_REG_CTL_HYST: ctl_hyst_q <= CFG_WDATA;
        SAC_REG_ALM_HYST: alm_hyst_q <= CFG_WDATA;
        SAC_REG_LOCK1: first_lockout_byte_q <= CFG_WDATA[7:0];
        SAC_REG_LOCK3: third_lockout_byte_q <= CFG_WDATA[7:0];
        default: begin
          if (CFG_ADDR >= SAC_REG_LEVEL_BASE && CFG_ADDR < SAC_REG_LOCK1) begin
            level_q[2'(CFG_ADDR - SAC_REG_LEVEL_BASE)] <= CFG_WDATA;
          end
        end
      endcase
    end
  end

  // per-channel thresholds, offsets and source
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic [7:0] cfg;
      logic [1:0] place;
      int k;
      cfg = '0;
      place = '0;
      k = i % 2;
      cfg = (i >= 2) ? alarm_setpoint_config_q : control_setpoint_config_q;
      dir[i] = cfg[k*SAC_CH_STRIDE + SAC_DIR_OFS];
      pol[i] = cfg[k*SAC_CH_STRIDE + SAC_POL_OFS];
      meas_sel[i] = cfg[k*SAC_CH_STRIDE + SAC_SRC_OFS] ? widen(MEAS_FILT) : widen(MEAS_RAW);
      band[i] = 1'b0;
      if (i < 2) begin
        // balanced: half the band each side of the level
        thr_lo[i] = widen(level_q[i]);
        thr_hi[i] = widen(level_q[i]);
        ofs_enter[i] = widen(ctl_hyst_q) >>> 1;
        ofs_stay[i] = widen(ctl_hyst_q) >>> 1;
      end else begin
        // whole band on the inactive side, none on entry
        place = alm_func_q[k*SAC_CH_STRIDE + SAC_PLACE_OFS +: 2];
        ofs_enter[i] = '0;
        ofs_stay[i] = widen(alm_hyst_q);
        case (place)
          SAC_PLACE_ABOVE: begin
            thr_lo[i] = widen(level_q[k]) + widen(level_q[i]);
            thr_hi[i] = thr_lo[i];
          end
          SAC_PLACE_BELOW: begin
            thr_lo[i] = widen(level_q[k]) - widen(level_q[i]);
            thr_hi[i] = thr_lo[i];
          end
          SAC_PLACE_BAND: begin
            thr_hi[i] = widen(level_q[k]) + widen(level_q[i]);
            thr_lo[i] = widen(level_q[k]) - widen(level_q[i]);
            band[i] = 1'b1;
          end
          default: begin
            thr_lo[i] = widen(level_q[i]);
            thr_hi[i] = widen(level_q[i]);
          end
        endcase
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_zone
    sac_zone_eval #(.W(TW)) u_zone (
      .meas(meas_sel[g]),
      .lo(thr_lo[g]),
      .hi(thr_hi[g]),
      .enter_ofs(ofs_enter[g]),
      .stay_ofs(ofs_stay[g]),
      .band(band[g]),
      .below(dir[g]),
      .enter(enter[g]),
      .stay(stay[g])
    );
  end

  for (genvar g = 0; g < 2; g++) begin : g_alm_set
    assign latch_en[g] = alm_func_q[g*SAC_CH_STRIDE + SAC_LATCH_OFS];
    assign set_now[g] = MEAS_VALID && enter[g+2] &&
                        (dcnt_q[g] >= alarm_delay_count_q[g*SAC_DELAY_W +: SAC_DELAY_W]);
  end

  // control pair: plain follow of the zone, never latched
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctl_act_q <= '0;
    end else if (ctl_pair_disable) begin
      ctl_act_q <= '0;
    end else if (MEAS_VALID) begin
      for (int i = 0; i < 2; i++) begin
        ctl_act_q[i] <= ctl_act_q[i] ? stay[i] : enter[i];
      end
    end
  end

  // alarm pair with delay counters and latches; a set beats a clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      alm_act_q <= '0;
      dcnt_q[0] <= '0;
      dcnt_q[1] <= '0;
    end else if (alm_pair_disable) begin
      alm_act_q <= '0;
      dcnt_q[0] <= '0;
      dcnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (alm_act_q[i] && latch_en[i]) begin
          if (latch_clear) begin
            alm_act_q[i] <= set_now[i];
          end
        end else if (alm_act_q[i]) begin
          if (MEAS_VALID) begin
            alm_act_q[i] <= stay[i+2];
          end
        end else if (MEAS_VALID) begin
          if (set_now[i]) begin
            alm_act_q[i] <= 1'b1;
            dcnt_q[i] <= '0;
          end else if (enter[i+2]) begin
            dcnt_q[i] <= dcnt_q[i] + 1'b1;
          end else begin
            dcnt_q[i] <= '0;
          end
        end
      end
    end
  end

  // outputs one cycle behind the states; disabled pairs show idle polarity
  always_ff @(posedge MCLK) begin
    if (RST) begin
      oc_q <= '0;
      led_q <= '0;
    end else begin
      oc_q <= active_q ^ pol;
      led_q[1:0] <= active_q[1:0] & {2{!ctl_pair_disable && !ctl_indicator_disable}};
      led_q[3:2] <= active_q[3:2] & {2{!alm_pair_disable}};
    end
  end

  // readback; unmapped indices read zero
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= '0;
    end else begin
      case (CFG_ADDR)
        SAC_REG_CTL_CFG: rdata_q <= MEAS_W'(control_setpoint_config_q);
        SAC_REG_ALM_CFG: rdata_q <= MEAS_W'(alarm_setpoint_config_q);
        SAC_REG_ALM_FUNC: rdata_q <= MEAS_W'(alm_func_q);
        SAC_REG_ALM_DELAY: rdata_q <= MEAS_W'(alarm_delay_count_q);
        SAC_REG_CTL_HYST: rdata_q <= ctl_hyst_q;
        SAC_REG_ALM_HYST: rdata_q <= alm_hyst_q;
        SAC_REG_LOCK1: rdata_q <= MEAS_W'(first_lockout_byte_q);
        SAC_REG_LOCK3: rdata_q <= MEAS_W'(third_lockout_byte_q);
        SAC_REG_STATUS: rdata_q <= MEAS_W'({led_q, oc_q, active_q});
        default: begin
          if (CFG_ADDR >= SAC_REG_LEVEL_BASE && CFG_ADDR < SAC_REG_LOCK1) begin
            rdata_q <= level_q[2'(CFG_ADDR - SAC_REG_LEVEL_BASE)];
          end else begin
            rdata_q <= '0;
          end
        end
      endcase
    end
  end

  assign CFG_RDATA = rdata_q;
  assign active_q = {alm_act_q, ctl_act_q};
  assign SP_ACTIVE = active_q;
  assign OC_ON = oc_q;
  assign LED_ON = led_q;

  // checks on the evaluated states and outputs
  a_ctl_pair_off: assert property (@(posedge MCLK) disable iff (RST)
    ctl_pair_disable |=> (active_q[1:0] == 2'h0) ##1 (OC_ON[1:0] == $past(pol[1:0])))
    else $error("control pair active while disabled");

  a_alm_pair_off: assert property (@(posedge MCLK) disable iff (RST)
    alm_pair_disable |=> (active_q[3:2] == 2'h0) ##1 (LED_ON[3:2] == 2'h0))
    else $error("alarm pair active while disabled");

  a_oc_polarity: assert property (@(posedge MCLK) disable iff (RST)
    ##1 (OC_ON == ($past(active_q) ^ $past(pol))))
    else $error("output transistor disagrees with polarity");

  a_ctl_led_gate: assert property (@(posedge MCLK) disable iff (RST)
    ctl_indicator_disable |=> (LED_ON[1:0] == 2'h0))
    else $error("control light lit while lights disabled");

  a_latch_hold: assert property (@(posedge MCLK) disable iff (RST)
    (active_q[2] && latch_en[0] && !latch_clear && !alm_pair_disable) |=> active_q[2])
    else $error("latched alarm dropped without a reset");

  a_ctl_no_latch: assert property (@(posedge MCLK) disable iff (RST)
    (MEAS_VALID && active_q[0] && !stay[0]) |=> !active_q[0])
    else $error("control setpoint held past its release point");

  a_alarm_immediate: assert property (@(posedge MCLK) disable iff (RST)
    (MEAS_VALID && !active_q[3] && enter[3] && !alm_pair_disable &&
     (alarm_delay_count_q[SAC_DELAY_W +: SAC_DELAY_W] == '0)) |=> active_q[3])
    else $error("undelayed alarm did not set on its reading");

  a_hold_between: assert property (@(posedge MCLK) disable iff (RST)
    (!MEAS_VALID && !latch_clear && !ctl_pair_disable && !alm_pair_disable) |=> $stable(active_q))
    else $error("state changed with no new reading");

  a_panel_lockout: assert property (@(posedge MCLK) disable iff (RST)
    (CFG_WE && !CFG_FROM_SERIAL && !jumper_in && CFG_ADDR == SAC_REG_CTL_CFG)
    |=> $stable(control_setpoint_config_q))
    else $error("panel write passed a missing jumper");

endmodule

//--- dv/sac_meas_model.sv
`timescale 1ns/10ps
module sac_meas_model import sac_pkg::*; #(
  parameter int MEAS_W = SAC_MEAS_W_DEF
) (
  input wire logic mclk,
  output logic meas_valid,
  output logic signed [MEAS_W-1:0] meas_raw,
  output logic signed [MEAS_W-1:0] meas_filt
);
  // idle front end at time zero
  initial begin
    meas_valid = 1'b0;
    meas_raw = '0;
    meas_filt = '0;
  end

  // one reading per call, one cycle of valid
  // lines are inverted afterwards so a stale sample can never pass for a match
  task automatic send(input logic signed [MEAS_W-1:0] raw, input logic signed [MEAS_W-1:0] filt);
    @(negedge mclk);
    meas_valid = 1'b1;
    meas_raw = raw;
    meas_filt = filt;
    @(negedge mclk);
    meas_valid = 1'b0;
    meas_raw = ~raw;
    meas_filt = ~filt;
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top import sac_pkg::*;;
  localparam int MW = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ext_n = 1'b1;
  logic btn_n = 1'b1;
  logic jmp = 1'b0;
  logic clr = 1'b0;
  logic we = 1'b0;
  logic ser = 1'b0;
  logic [SAC_ADDR_W-1:0] addr = '0;
  logic [MW-1:0] wdata = '0;
  logic [MW-1:0] rdata;
  logic [3:0] act;
  logic [3:0] oc;
  logic [3:0] led;
  logic valid;
  logic signed [MW-1:0] raw;
  logic signed [MW-1:0] filt;
  logic [7:0] ccfg = 8'h00;
  logic [7:0] acfg = 8'h00;
  int n_errors = 0;
  int checked = 0;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  sac_meas_model #(.MEAS_W(MW)) meas_u (.mclk(mclk), .meas_valid(valid), .meas_raw(raw), .meas_filt(filt));

  sac_setpoint_alarm #(.MEAS_W(MW)) dut_u (.MCLK(mclk), .RST(rst), .MEAS_VALID(valid), .MEAS_RAW(raw),
    .MEAS_FILT(filt), .EXTERNAL_RESET_PIN_N(ext_n), .RESET_BUTTON_N(btn_n), .LOCK_JUMPER(jmp),
    .SER_LATCH_CLEAR(clr), .CFG_WE(we), .CFG_FROM_SERIAL(ser), .CFG_ADDR(addr), .CFG_WDATA(wdata),
    .CFG_RDATA(rdata), .SP_ACTIVE(act), .OC_ON(oc), .LED_ON(led));

  // expected outputs from the shadow config bytes
  function automatic logic [3:0] x_oc(input logic [3:0] a);
    return a ^ {acfg[4], acfg[1], ccfg[4], ccfg[1]};
  endfunction
  function automatic logic [3:0] x_led(input logic [3:0] a);
    return a & {{2{~acfg[6]}}, {2{~ccfg[6] & ~ccfg[7]}}};
  endfunction

  // comparisons, one per kind of result
  task automatic cmp_state(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [MW-1:0] got, input logic [MW-1:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // state now, transistors and lights one cycle later
  task automatic chk(input logic [3:0] a);
    cmp_state(act, a);
    @(negedge mclk);
    cmp_state(oc, x_oc(a));
    cmp_state(led, x_led(a));
  endtask
  task automatic m(input logic [MW-1:0] r, input logic [MW-1:0] f, input logic [3:0] a);
    meas_u.send(r, f);
    chk(a);
  endtask

  // register port; shadows track only serial writes, which are never locked
  task automatic wr(input logic [3:0] ad, input logic [MW-1:0] d, input logic s);
    @(negedge mclk);
    we = 1'b1;
    ser = s;
    addr = ad;
    wdata = d;
    @(negedge mclk);
    we = 1'b0;
    if (s && ad == SAC_REG_CTL_CFG) ccfg = d[7:0];
    if (s && ad == SAC_REG_ALM_CFG) acfg = d[7:0];
  endtask
  task automatic rdc(input logic [3:0] ad, input logic [MW-1:0] e);
    @(negedge mclk);
    addr = ad;
    @(negedge mclk);
    cmp_reg(rdata, e);
  endtask

  // latch clear sources
  task automatic sclr(input logic [3:0] a);
    @(negedge mclk);
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    chk(a);
  endtask
  // pin held low long enough to pass the synchronisers
  task automatic hit(input int sel, input logic [3:0] a);
    @(negedge mclk);
    if (sel == 0) ext_n = 1'b0;
    else btn_n = 1'b0;
    repeat (8) @(negedge mclk);
    ext_n = 1'b1;
    btn_n = 1'b1;
    cmp_state(act, a);
  endtask

  task automatic conclude;
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i <= 12; i++) rdc(4'(i), 20'h0_0000);
    // lockout: jumper, third byte, first byte
    wr(SAC_REG_CTL_HYST, 20'h0_0009, 1'b0);
    rdc(SAC_REG_CTL_HYST, 20'h0_0000);
    jmp = 1'b1;
    repeat (4) @(negedge mclk);
    wr(SAC_REG_CTL_HYST, 20'h0_0008, 1'b0);
    rdc(SAC_REG_CTL_HYST, 20'h0_0008);
    wr(SAC_REG_LOCK3, 20'h0_0002, 1'b1);
    wr(SAC_REG_CTL_HYST, 20'h0_0009, 1'b0);
    rdc(SAC_REG_CTL_HYST, 20'h0_0008);
    wr(SAC_REG_ALM_HYST, 20'h0_000a, 1'b1);
    rdc(SAC_REG_ALM_HYST, 20'h0_000a);
    wr(SAC_REG_LOCK3, 20'h0_0000, 1'b1);
    wr(SAC_REG_LOCK1, 20'h0_0001, 1'b1);
    wr(4'h6, 20'h0_0063, 1'b0);
    rdc(4'h6, 20'h0_0000);
    wr(4'h7, 20'h0_00c8, 1'b0);
    rdc(4'h7, 20'h0_00c8);
    wr(SAC_REG_LOCK1, 20'h0_0000, 1'b1);
    wr(4'h6, 20'h0_0064, 1'b1);
    wr(4'h8, 20'h0_012c, 1'b1);
    wr(4'h9, 20'h0_0190, 1'b1);
    // control A at 100, band 8: on above 104, off below 96
    m(20'h0_0068, 20'h0_0000, 4'h0);
    m(20'h0_0069, 20'h0_0000, 4'h1);
    m(20'h0_0060, 20'h0_0000, 4'h1);
    m(20'h0_005f, 20'h0_0000, 4'h0);
    wr(SAC_REG_CTL_CFG, 20'h0_0004, 1'b1);
    m(20'h0_0000, 20'h0_0069, 4'h1);
    m(20'h0_0069, 20'h0_0000, 4'h0);
    wr(SAC_REG_CTL_CFG, 20'h0_0003, 1'b1);
    m(20'h0_005f, 20'h0_0000, 4'h1);
    m(20'h0_0068, 20'h0_0000, 4'h1);
    m(20'h0_0069, 20'h0_0000, 4'h0);
    wr(SAC_REG_CTL_CFG, 20'h0_0018, 1'b1);
    m(20'h0_00c3, 20'h0_0000, 4'h3);
    m(20'h0_00cd, 20'h0_0000, 4'h1);
    wr(SAC_REG_CTL_CFG, 20'h0_0020, 1'b1);
    m(20'h0_0000, 20'h0_00cd, 4'h2);
    m(20'h0_0000, 20'h0_0000, 4'h0);
    wr(SAC_REG_CTL_CFG, 20'h0_0080, 1'b1);
    m(20'h0_0069, 20'h0_0000, 4'h1);
    wr(SAC_REG_CTL_CFG, 20'h0_00c2, 1'b1);
    // the disable bit acts one edge after it is written
    @(negedge mclk);
    chk(4'h0);
    m(20'h0_0069, 20'h0_0000, 4'h0);
    // alarm A at 300, band 10 on the inactive side
    m(20'h0_012d, 20'h0_0000, 4'h4);
    rdc(SAC_REG_STATUS, {8'h00, x_led(4'h4), x_oc(4'h4), 4'h4});
    wr(4'hd, 20'h0_00ff, 1'b1);
    wr(SAC_REG_STATUS, 20'h0_0000, 1'b1);
    rdc(SAC_REG_STATUS, {8'h00, x_led(4'h4), x_oc(4'h4), 4'h4});
    m(20'h0_0122, 20'h0_0000, 4'h4);
    wr(SAC_REG_ALM_CFG, 20'h0_0042, 1'b1);
    @(negedge mclk);
    chk(4'h0);
    wr(SAC_REG_ALM_CFG, 20'h0_0000, 1'b1);
    m(20'h0_012d, 20'h0_0000, 4'h4);
    m(20'h0_0121, 20'h0_0000, 4'h0);
    wr(SAC_REG_ALM_CFG, 20'h0_0007, 1'b1);
    m(20'h0_0000, 20'h0_012b, 4'h4);
    m(20'h0_0000, 20'h0_0136, 4'h4);
    m(20'h0_0000, 20'h0_0137, 4'h0);
    wr(SAC_REG_ALM_CFG, 20'h0_0020, 1'b1);
    m(20'h0_0000, 20'h0_0191, 4'h8);
    m(20'h0_0191, 20'h0_0000, 4'h4);
    m(20'h0_0000, 20'h0_0000, 4'h0);
    // placements around control A at 100 with amount 20, then alarm B above control B at 200 with amount 400
    wr(SAC_REG_ALM_CFG, 20'h0_0000, 1'b1);
    wr(4'h8, 20'h0_0014, 1'b1);
    wr(SAC_REG_ALM_FUNC, 20'h0_0001, 1'b1);
    m(20'h0_0079, 20'h0_0000, 4'h4);
    m(20'h0_006e, 20'h0_0000, 4'h4);
    m(20'h0_006d, 20'h0_0000, 4'h0);
    wr(SAC_REG_ALM_FUNC, 20'h0_0002, 1'b1);
    m(20'h0_0051, 20'h0_0000, 4'h4);
    m(20'h0_0000, 20'h0_0000, 4'h0);
    wr(SAC_REG_ALM_FUNC, 20'h0_0003, 1'b1);
    m(20'h0_0079, 20'h0_0000, 4'h4);
    m(20'h0_006e, 20'h0_0000, 4'h4);
    m(20'h0_0064, 20'h0_0000, 4'h0);
    m(20'h0_004f, 20'h0_0000, 4'h4);
    m(20'h0_005a, 20'h0_0000, 4'h4);
    m(20'h0_005b, 20'h0_0000, 4'h0);
    wr(SAC_REG_ALM_CFG, 20'h0_0001, 1'b1);
    m(20'h0_0064, 20'h0_0000, 4'h4);
    m(20'h0_0082, 20'h0_0000, 4'h4);
    m(20'h0_0083, 20'h0_0000, 4'h0);
    wr(SAC_REG_ALM_FUNC, 20'h0_0008, 1'b1);
    m(20'h0_0259, 20'h0_0000, 4'h8);
    m(20'h0_024d, 20'h0_0000, 4'h0);
    // delay of 2: third consecutive reading sets, a gap restarts the count
    wr(SAC_REG_ALM_CFG, 20'h0_0000, 1'b1);
    wr(SAC_REG_ALM_FUNC, 20'h0_0000, 1'b1);
    wr(SAC_REG_ALM_DELAY, 20'h0_0002, 1'b1);
    m(20'h0_0015, 20'h0_0000, 4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h0);
    m(20'h0_0000, 20'h0_0000, 4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h4);
    wr(SAC_REG_ALM_DELAY, 20'h0_0000, 1'b1);
    m(20'h0_0000, 20'h0_0000, 4'h0);
    // latching: alarms hold, control never does; each clear source in turn
    wr(SAC_REG_CTL_CFG, 20'h0_0000, 1'b1);
    wr(SAC_REG_ALM_FUNC, 20'h0_0024, 1'b1);
    m(20'h0_0069, 20'h0_0000, 4'h5);
    m(20'h0_0000, 20'h0_0000, 4'h4);
    sclr(4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h4);
    m(20'h0_0000, 20'h0_0000, 4'h4);
    hit(0, 4'h4);
    wr(SAC_REG_ALM_CFG, 20'h0_0080, 1'b1);
    hit(0, 4'h0);
    m(20'h0_0015, 20'h0_0000, 4'h4);
    m(20'h0_0000, 20'h0_0000, 4'h4);
    hit(1, 4'h0);
    // alarm B: latching band 600 / -200 around control B, delay of one reading
    wr(SAC_REG_ALM_FUNC, 20'h0_0038, 1'b1);
    wr(SAC_REG_ALM_DELAY, 20'h0_0080, 1'b1);
    m(20'h0_0259, 20'h0_0000, 4'h7);
    m(20'h0_0259, 20'h0_0000, 4'hf);
    m(20'h0_0000, 20'h0_0000, 4'h8);
    sclr(4'h0);
    conclude();
  end
endmodule
